// ### common/timer_irq_regs.vh
// Constants for the timer interrupt request arbiter
//
// Functional notes
// - Eleven maskable sources; two 8-bit mask bytes, byte or word access, reset zero.
// - Mask bit shares its flag's position; request needs flag and mask both set.
// - Three-bit request level picks one of seven request lines, 7 highest.
// - Request level zero asserts no request line at all.
// - Join arbitration only when acknowledged level equals our current request level.
// - Arbitrate by serially asserting 4-bit identifier bits; identifiers distinct and non-zero.
// - After winning, drive the vector number onto the data lines.
// - Vector is base nibble on top, serviced source code underneath.
// - Vector held stable while driven, whatever base or pending sources do.
// - Vector base nibble clears to zero on reset.
// - Source codes 1-3 captures, 4-7 compares, 8 shared, 9-11 overflow/accumulator.
// - Among pending enabled sources, lowest source code is serviced first.
// - Priority adjust raises matching source above all; it reports code zero.
// - Request holds until flag cleared; clear needs read-set then write-zero; events win.
// - Only hardware sets flags; writing one sets nothing; flags reset to zero.
`ifndef TIMER_IRQ_REGS_VH
`define TIMER_IRQ_REGS_VH

// ****************************************************************
// Register selects on the access port
// ****************************************************************
`define SEL_EVENT_MASK      2'h0
`define SEL_EVENT_FLAGS     2'h1
`define SEL_IRQ_CONFIG      2'h2
`define SEL_MODULE_CONFIG   2'h3

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SRC_COUNT           11
`define SRC_TOP_BIT         15
`define LOW_BYTE_SRCS       8
`define CFG_LEVEL_MSB       10
`define CFG_LEVEL_LSB       8
`define CFG_BASE_MSB        7
`define CFG_BASE_LSB        4
`define CFG_ADJ_MSB         3
`define CFG_ADJ_LSB         0
`define MCR_ARB_MSB         3
`define MCR_ARB_LSB         0
`define RST_SOURCES         11'h000
`define RST_NIBBLE          4'h0
`define RST_LEVEL           3'h0
`define RST_WORD            16'h0000
`define ARB_BITS_TOP        2'h3

`endif

// ### core/timer_interrupt_request_arbiter.v
// Interrupt request, priority, arbitration and vectoring for the timer
`timescale 1ns/10ps
`default_nettype none
`include "timer_irq_regs.vh"

module timer_interrupt_request_arbiter (
   // Clock and reset
   input  wire        clock_i,
   input  wire        rstn_i,
   // Event pulses from the timer units, index = source code - 1
   input  wire [10:0] event_i,
   // Register access port
   input  wire        reg_rd_i,
   input  wire        reg_wr_i,
   input  wire [1:0]  reg_sel_i,
   input  wire [1:0]  byte_en_i,
   input  wire [15:0] reg_wdata_i,
   output reg  [15:0] reg_rdata_o,
   // Request lines, bit n-1 is line n
   output reg  [6:0]  irq_o,
   // Acknowledge cycle
   input  wire        iack_i,
   input  wire [2:0]  iack_level_i,
   // Serial arbitration line, wired-OR, high = asserted
   input  wire        arb_i,
   output reg         arb_o,
   output reg         arb_oe_o,
   // Vector on the data lines
   output reg  [7:0]  data_o,
   output reg         data_oe_o
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_ARB   = 2'h1;
   localparam [1:0] ST_DRIVE = 2'h2;
   localparam [1:0] ST_WAIT  = 2'h3;

   // ****************************************************************
   // Storage
   // ****************************************************************
   reg  [10:0] event_mask;
   reg  [10:0] event_flags;
   reg  [10:0] clear_armed;
   reg  [2:0]  request_level;
   reg  [3:0]  vector_base_nibble;
   reg  [3:0]  priority_adjust;
   reg  [3:0]  arbitration_id;
   reg  [1:0]  state;
   reg  [1:0]  arb_bit;
   reg         iack_prev;
   reg  [7:0]  vector_hold;

   // Next values and word views, all combinational
   reg  [10:0] next_flags;
   reg  [10:0] next_armed;
   reg  [10:0] next_mask;
   reg  [15:0] mask_word;
   reg  [15:0] flag_word;
   reg  [3:0]  src_code;
   reg         lane;
   integer     i;

   // Decoded strobes and request state
   wire [10:0] pending;
   wire        any_pending;
   wire        wr_mask;
   wire        wr_flags;
   wire        rd_flags;
   wire        wr_icr;
   wire        wr_mcr;
   wire        start_arb;

   // ****************************************************************
   // Strobe decode
   // ****************************************************************
   // One strobe a cycle; a read and a write together is not supported
   assign wr_mask  = reg_wr_i & (reg_sel_i == `SEL_EVENT_MASK);
   assign wr_flags = reg_wr_i & (reg_sel_i == `SEL_EVENT_FLAGS);
   assign rd_flags = reg_rd_i & (reg_sel_i == `SEL_EVENT_FLAGS);
   assign wr_icr   = reg_wr_i & (reg_sel_i == `SEL_IRQ_CONFIG);
   assign wr_mcr   = reg_wr_i & (reg_sel_i == `SEL_MODULE_CONFIG);

   // A source asks only while flag and mask are both set
   assign pending     = event_flags & event_mask;
   assign any_pending = |pending;

   // ****************************************************************
   // Flag, mask and word views
   // ****************************************************************
   // Source code c sits at word bit 16-c; upper byte lane holds codes 1-8
   always @* begin
      next_flags = event_flags;
      next_armed = clear_armed;
      next_mask  = event_mask;
      mask_word  = `RST_WORD;
      flag_word  = `RST_WORD;
      lane       = 1'b0;
      for (i = 0; i < `SRC_COUNT; i = i + 1) begin
         lane = (i < `LOW_BYTE_SRCS) ? byte_en_i[1] : byte_en_i[0];
         mask_word[`SRC_TOP_BIT - i] = event_mask[i];
         flag_word[`SRC_TOP_BIT - i] = event_flags[i];
         if (wr_mask && lane) begin
            next_mask[i] = reg_wdata_i[`SRC_TOP_BIT - i];
         end
         // A read that sees the flag set arms its clear
         if (rd_flags && lane) begin
            next_armed[i] = event_flags[i];
         end
         // Write of zero clears only an armed flag; write of one leaves the flag; any write disarms
         if (wr_flags && lane) begin
            next_armed[i] = 1'b0;
            if (!reg_wdata_i[`SRC_TOP_BIT - i] && clear_armed[i]) begin
               next_flags[i] = 1'b0;
            end
         end
         // Events win over a clear in the same cycle; an event after the
         // read cancels the armed clear so the new event is not lost
         if (event_i[i]) begin
            next_flags[i] = 1'b1;
            next_armed[i] = 1'b0;
         end
      end
   end

   // Registered flag and mask state, zero after reset
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         event_mask  <= `RST_SOURCES;
         event_flags <= `RST_SOURCES;
         clear_armed <= `RST_SOURCES;
      end else begin
         event_mask  <= next_mask;
         event_flags <= next_flags;
         clear_armed <= next_armed;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   // Upper byte lane holds level, lower lane holds base and adjust
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         request_level      <= `RST_LEVEL;
         vector_base_nibble <= `RST_NIBBLE;
         priority_adjust    <= `RST_NIBBLE;
         arbitration_id     <= `RST_NIBBLE;
      end else begin
         if (wr_icr && byte_en_i[1]) begin
            request_level <= reg_wdata_i[`CFG_LEVEL_MSB:`CFG_LEVEL_LSB];
         end
         if (wr_icr && byte_en_i[0]) begin
            vector_base_nibble <= reg_wdata_i[`CFG_BASE_MSB:`CFG_BASE_LSB];
            priority_adjust    <= reg_wdata_i[`CFG_ADJ_MSB:`CFG_ADJ_LSB];
         end
         // Identifier in the lower lane; the upper lane of this word is unused
         if (wr_mcr && byte_en_i[0]) begin
            arbitration_id <= reg_wdata_i[`MCR_ARB_MSB:`MCR_ARB_LSB];
         end
      end
   end

   // Read data lands one cycle after the read strobe
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= `RST_WORD;
      end else if (reg_rd_i) begin
         case (reg_sel_i)
            `SEL_EVENT_MASK:  reg_rdata_o <= mask_word;
            `SEL_EVENT_FLAGS: reg_rdata_o <= flag_word;
            `SEL_IRQ_CONFIG:  reg_rdata_o <= {5'h00, request_level,
                                              vector_base_nibble, priority_adjust};
            // Module config: only the identifier nibble reads back
            default:          reg_rdata_o <= {12'h000, arbitration_id};
         endcase
      end else begin
         reg_rdata_o <= `RST_WORD;
      end
   end

   // ****************************************************************
   // Source priority
   // ****************************************************************
   // Scan from the top so the lowest code is assigned last and wins
   always @* begin
      src_code = 4'h0;
      for (i = `SRC_COUNT - 1; i >= 0; i = i - 1) begin
         if (pending[i]) begin
            src_code = i[3:0] + 4'h1;
         end
      end
      // Adjusted source beats everything and reports code zero
      // An adjust value that names no pending source changes nothing
      for (i = 0; i < `SRC_COUNT; i = i + 1) begin
         if (pending[i] && (priority_adjust == i[3:0] + 4'h1)) begin
            src_code = 4'h0;
         end
      end
   end

   // ****************************************************************
   // Request lines
   // ****************************************************************
   // Held while any enabled flag remains, including after a lost cycle
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         irq_o <= 7'h00;
      end else if (any_pending && (request_level != 3'h0)) begin
         irq_o <= 7'h01 << (request_level - 3'h1);
      end else begin
         irq_o <= 7'h00;
      end
   end

   // ****************************************************************
   // Acknowledge arbitration and vector
   // ****************************************************************
   // Join only on the leading edge of a matching acknowledge; a zero
   // identifier would never win the wired-OR, so it stays out
   assign start_arb = iack_i && !iack_prev && (state == ST_IDLE) &&
                      any_pending && (request_level != 3'h0) &&
                      (iack_level_i == request_level) &&
                      (arbitration_id != 4'h0);

   // Identifier goes out MSB first, one bit a cycle; a zero bit that
   // meets an asserted line has lost
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         state       <= ST_IDLE;
         arb_bit     <= 2'h0;
         iack_prev   <= 1'b0;
         arb_o       <= 1'b0;
         arb_oe_o    <= 1'b0;
         data_o      <= 8'h00;
         data_oe_o   <= 1'b0;
         vector_hold <= 8'h00;
      end else begin
         // Edge detector resets low, the idle level of the acknowledge
         iack_prev <= iack_i;
         case (state)
            ST_IDLE: begin
               // Off the data lines unless this block has won
               data_oe_o <= 1'b0;
               if (start_arb) begin
                  // Vector frozen here so later changes cannot reach the bus
                  vector_hold <= {vector_base_nibble, src_code};
                  arb_bit     <= `ARB_BITS_TOP;
                  arb_o       <= arbitration_id[3];
                  arb_oe_o    <= arbitration_id[3];
                  state       <= ST_ARB;
               end
            end
            ST_ARB: begin
               // Acknowledge withdrawn mid-arbitration: abort quietly
               if (!iack_i) begin
                  arb_o    <= 1'b0;
                  arb_oe_o <= 1'b0;
                  state    <= ST_IDLE;
               end else if (!arb_oe_o && arb_i) begin
                  arb_o    <= 1'b0;
                  arb_oe_o <= 1'b0;
                  state    <= ST_WAIT;
               end else if (arb_bit == 2'h0) begin
                  arb_o     <= 1'b0;
                  arb_oe_o  <= 1'b0;
                  data_o    <= vector_hold;
                  data_oe_o <= 1'b1;
                  state     <= ST_DRIVE;
               end else begin
                  arb_bit  <= arb_bit - 2'h1;
                  arb_o    <= arbitration_id[arb_bit - 2'h1];
                  arb_oe_o <= arbitration_id[arb_bit - 2'h1];
               end
            end
            ST_DRIVE: begin
               // Vector stays put until the acknowledge ends
               if (!iack_i) begin
                  data_oe_o <= 1'b0;
                  state     <= ST_IDLE;
               end else begin
                  data_o <= vector_hold;
               end
            end
            ST_WAIT: begin
               // Lost: stay off the bus, request lines untouched
               if (!iack_i) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               // Unused state code: back to idle
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // timer_interrupt_request_arbiter
`default_nettype wire

// ### testbench/timer_irq_checker_assertions.sv
// Port-level assertions for the timer interrupt request arbiter
`timescale 1ns/10ps
`default_nettype none
module timer_irq_checker (
   // Clock and reset
   input wire        clock_i,
   input wire        rstn_i,
   // Watched design ports
   input wire        reg_rd_i,
   input wire [15:0] reg_rdata_o,
   input wire [6:0]  irq_o,
   input wire        iack_i,
   input wire [2:0]  iack_level_i,
   input wire        arb_oe_o,
   input wire [7:0]  data_o,
   input wire        data_oe_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // ****************************************************************
   // Request lines, read port, vector drive
   // ****************************************************************
   irq_onehot_a: assert property ($onehot0(irq_o))
      else $error("several request lines at once");
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data outside a read");
   arb_in_ack_a: assert property (arb_oe_o |-> $past(iack_i))
      else $error("arbitration drive outside acknowledge");
   drive_excl_a: assert property (!(data_oe_o && arb_oe_o))
      else $error("vector and arbitration driven together");
   data_start_a: assert property ($rose(data_oe_o) |-> $past(iack_i, 5) && iack_i)
      else $error("vector driven too early");
   level_match_a: assert property ($rose(data_oe_o) |-> irq_o[iack_level_i - 3'h1])
      else $error("vector at a level not requested");
   vec_stable_a: assert property (data_oe_o && $past(data_oe_o) |-> $stable(data_o))
      else $error("vector changed while driven");
   data_drop_a: assert property (!iack_i |=> !data_oe_o)
      else $error("vector still driven after acknowledge");
   // Main scenarios reached
   cover property ($rose(data_oe_o));
   cover property ($fell(arb_oe_o) && iack_i && !data_oe_o);
   cover property (irq_o[6]);
endmodule // timer_irq_checker
bind timer_interrupt_request_arbiter timer_irq_checker timer_irq_checker_inst (
   .clock_i(clock_i), .rstn_i(rstn_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .irq_o(irq_o), .iack_i(iack_i), .iack_level_i(iack_level_i), .arb_oe_o(arb_oe_o),
   .data_o(data_o), .data_oe_o(data_oe_o));
`default_nettype wire

// ### testbench/cpu_ack_model.sv
// Processor acknowledge side plus one rival requester on the arbitration line
`timescale 1ns/10ps
`default_nettype none
module cpu_ack_model (
   // Clock, reset and bench controls
   input  wire logic       clock_i,
   input  wire logic       rstn_i,
   input  wire logic       go_i,
   input  wire logic [2:0] ip_i,
   input  wire logic [3:0] rival_id_i,
   // Block side
   input  wire logic [6:0] irq_i,
   input  wire logic       arb_drive_i,
   input  wire logic       arb_en_i,
   output logic            iack_o,
   output logic      [2:0] level_o,
   output logic            arb_line_o
);
   logic [2:0] top;
   logic [2:0] lvl;
   logic [3:0] cnt;
   logic       out;
   logic       rbit;
   // Highest asserted request line
   always @* begin
      top = 3'h0;
      for (int k = 0; k < 7; k++)
         if (irq_i[k]) top = 3'(k + 1);
   end
   // Rival shifts its identifier MSB first in the block's slots; wired-OR line
   assign rbit = iack_o && !out && cnt >= 4'h1 && cnt <= 4'h4 && rival_id_i[4'h4 - cnt];
   assign arb_line_o = (arb_en_i & arb_drive_i) | rbit;
   // Released address lines show the inverse, never a stale level
   assign level_o = iack_o ? lvl : ~lvl;
   // Acknowledge sequencer; only levels above the mask are honoured
   always @(posedge clock_i) begin
      if (!rstn_i) begin
         iack_o <= 1'b0;
         cnt <= 4'h0;
         out <= 1'b0;
      end else if (!iack_o) begin
         cnt <= 4'h0;
         out <= 1'b0;
         iack_o <= go_i && top > ip_i;
         lvl <= top;
      end else begin
         cnt <= cnt + 4'h1;
         if (cnt == 4'h9) iack_o <= 1'b0;
         if (cnt >= 4'h1 && cnt <= 4'h4 && !rbit && arb_line_o) out <= 1'b1;
      end
   end
endmodule // cpu_ack_model
`default_nettype wire

// ### testbench/timer_interrupt_request_arbiter_tb.sv
// Self-checking bench for the timer interrupt request arbiter
`timescale 1ns/10ps
`default_nettype none
module timer_interrupt_request_arbiter_tb;
   logic        clock_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [10:0] event_i = 11'h000;
   logic        reg_rd_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic [1:0]  reg_sel_i = 2'h0;
   logic [1:0]  byte_en_i = 2'h3;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic        go = 1'b0;
   logic [2:0]  ip = 3'h0;
   logic [3:0]  rival = 4'h0;
   wire  [15:0] reg_rdata_o;
   wire  [6:0]  irq_o;
   wire  [2:0]  iack_level_i;
   wire  [7:0]  data_o;
   wire         iack_i, arb_i, arb_o, arb_oe_o, data_oe_o;
   int          n_fail = 0;
   int          comparisons = 0;
   // ****************************************************************
   // Block, acknowledge partner, clock, watchdog
   // ****************************************************************
   timer_interrupt_request_arbiter timer_interrupt_request_arbiter_inst (
      .clock_i(clock_i), .rstn_i(rstn_i), .event_i(event_i), .reg_rd_i(reg_rd_i),
      .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i), .byte_en_i(byte_en_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .iack_i(iack_i),
      .iack_level_i(iack_level_i), .arb_i(arb_i), .arb_o(arb_o), .arb_oe_o(arb_oe_o),
      .data_o(data_o), .data_oe_o(data_oe_o));
   cpu_ack_model cpu_ack_model_inst (
      .clock_i(clock_i), .rstn_i(rstn_i), .go_i(go), .ip_i(ip), .rival_id_i(rival),
      .irq_i(irq_o), .arb_drive_i(arb_o), .arb_en_i(arb_oe_o), .iack_o(iack_i),
      .level_o(iack_level_i), .arb_line_o(arb_i));
   always #50 clock_i = ~clock_i;
   // Tests need well under 1000 cycles
   initial begin
      repeat (3000) @(posedge clock_i);
      n_fail++;
      complete_run;
   end
   // ****************************************************************
   // Access and compare tasks
   // ****************************************************************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle strobe; lanes and data held with it
   task acc(input logic rd, input logic [1:0] s, input logic [1:0] b, input logic [15:0] d);
      @(posedge clock_i);
      reg_rd_i <= rd;
      reg_wr_i <= !rd;
      reg_sel_i <= s;
      byte_en_i <= b;
      reg_wdata_i <= d;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      reg_wr_i <= 1'b0;
   endtask
   task rd(input logic [1:0] s, input logic [15:0] exp);
      acc(1'b1, s, 2'h3, 16'h0000);
      #1 chk(reg_rdata_o, exp);
   endtask
   // Request lines settle one cycle after a register change
   task irq_is(input logic [6:0] exp);
      repeat (3) @(posedge clock_i);
      #1 chk({9'h000, irq_o}, {9'h000, exp});
   endtask
   task ev(input int c);
      @(posedge clock_i);
      event_i <= 11'h001 << (c - 1);
      @(posedge clock_i);
      event_i <= 11'h000;
   endtask
   // Exp bit 8 says whether a vector is expected at all
   task ack(input logic [3:0] rv, input logic [8:0] exp);
      logic [8:0] got;
      got = 9'h000;
      @(posedge clock_i);
      rival <= rv;
      go <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      repeat (12) begin
         @(posedge clock_i);
         #1 if (data_oe_o === 1'b1) got = {1'b1, data_o};
      end
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      repeat (2) @(posedge clock_i);
      rstn_i <= 1'b1;
      rd(2'h0, 16'h0000);
      rd(2'h1, 16'h0000);
      rd(2'h2, 16'h0000);
      acc(1'b0, 2'h2, 2'h3, 16'h00a0);
      acc(1'b0, 2'h1, 2'h3, 16'hffff);
      rd(2'h1, 16'h0000);
      acc(1'b0, 2'h0, 2'h3, 16'hffff);
      rd(2'h0, 16'hffe0);
      acc(1'b0, 2'h0, 2'h1, 16'h0000);
      rd(2'h0, 16'hff00);
      $display("test 1 done");
      ev(1);
      irq_is(7'h00);
      for (int l = 1; l < 8; l++) begin
         acc(1'b0, 2'h2, 2'h3, {5'h00, l[2:0], 8'ha0});
         irq_is(7'h01 << (l - 1));
      end
      $display("test 2 done");
      ev(9);
      rd(2'h1, 16'h8080);
      ev(1);
      acc(1'b0, 2'h1, 2'h3, 16'h0000);
      rd(2'h1, 16'h8000);
      acc(1'b0, 2'h1, 2'h3, 16'h0000);
      rd(2'h1, 16'h0000);
      irq_is(7'h00);
      ev(9);
      irq_is(7'h00);
      $display("test 3 done");
      acc(1'b0, 2'h3, 2'h1, 16'h0006);
      acc(1'b0, 2'h0, 2'h3, 16'hffe0);
      acc(1'b0, 2'h2, 2'h3, 16'h05a0);
      ev(3);
      ack(4'h0, 9'h1a3);
      ack(4'h9, 9'h000);
      irq_is(7'h10);
      ack(4'h3, 9'h1a3);
      acc(1'b0, 2'h2, 2'h3, 16'h05a9);
      ack(4'h0, 9'h1a0);
      ip <= 3'h5;
      ack(4'h0, 9'h000);
      $display("test 4 done");
      complete_run;
   end
endmodule // timer_interrupt_request_arbiter_tb
`default_nettype wire
